// ==== rtl/scd_pkg.sv ====
/*
  Shared constants for the command pin decode block: pin widths,
  command codes, field positions, reset values and timing counts.
  Assumes a single 200 MHz clock and a synchronous active-high reset.
*/
package scd_pkg;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int DATA_W = 16;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int AP_BIT = 10;
  localparam int BURST_LEN = 4;
  localparam int READ_LATENCY = 2;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam logic [BANK_W-1:0] BANK_A = 2'h0;
  localparam logic [BANK_W-1:0] BANK_B = 2'h1;
  localparam logic [BANK_W-1:0] BANK_C = 2'h2;
  localparam logic [BANK_W-1:0] BANK_D = 2'h3;
  localparam logic [ROW_W-1:0] MODE_RST = 12'h000;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 4'h0;

  // Command code {row strobe, column strobe, write strobe}, all active low
  typedef enum logic [2:0] {
    CMD_MODE = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ROW_OPEN = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_STOP = 3'h6,
    CMD_NOP = 3'h7
  } scd_cmd_e;
endpackage

// ==== rtl/scd_mem.sv ====
/*
  Small synchronous storage array with per-byte write enables.
  Read data comes out of a register one cycle after the address.
  Assumes a single clock; contents are not reset.
*/
`timescale 1ns/10ps
`default_nettype none
module scd_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic mclk,
  input wire logic writeEn,
  input wire logic [1:0] byteEn,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [DW-1:0] writeData,
  input wire logic [AW-1:0] readAddr,
  output logic [DW-1:0] readData
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  // Elaboration check: the byte lanes below are wired for two bytes
  if (DW != 16) begin : gBadWidth
    $error("scd_mem supports 16-bit words only");
  end

  // Byte lanes written independently so a masked lane keeps old data
  always_ff @(posedge mclk) begin
    if (writeEn && byteEn[0]) begin
      store[writeAddr][7:0] <= writeData[7:0];
    end
    if (writeEn && byteEn[1]) begin
      store[writeAddr][15:8] <= writeData[15:8];
    end
  end

  // Registered read port
  always_ff @(posedge mclk) begin
    readData <= store[readAddr];
  end
endmodule
`default_nettype wire

// ==== rtl/scd_decode.sv ====
/*
  Command and address decode at the pins of a four-bank 16-bit
  synchronous DRAM, with row tracking, burst read and write, byte
  masks and a mode op-code latch. Assumes the controller drives all
  pins synchronous to mclk; data pin is split into in, out and enable.
*/
// What this block does
// - Strobes registered each edge define command
// - Chip select high ignores every command
// - Row strobe low: activate or precharge
// - Column strobe low starts column access
// - Row address sampled at activate
// - Column low nine bits, auto-precharge bit
// - Precharge bit ten high precharges all
// - Mode set loads op-code from address
// - Byte masks gate output and writes
// - Data bus synchronous, lanes maskable
// - Write strobe high reads burst sequentially
`timescale 1ns/10ps
`default_nettype none
module scd_decode
  import scd_pkg::*;
#(
  parameter int STORE_AW = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeStrobeN,
  input wire logic bank_select_msb,
  input wire logic bank_select_lsb,
  input wire logic [ROW_W-1:0] addrPins,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [DATA_W-1:0] dataBusIn,
  output logic [DATA_W-1:0] dataBusOut,
  output logic [DATA_W-1:0] dataBusOe,
  output logic [NUM_BANKS-1:0] bankActive,
  output logic [ROW_W-1:0] modeCode,
  output logic cmdError
);
  // Elaboration checks: storage fits the decoded address, pipes two deep
  if (STORE_AW < 4 || STORE_AW > MEM_AW) begin : gBadStoreAw
    $error("STORE_AW out of range");
  end
  if (READ_LATENCY != 2) begin : gBadLatency
    $error("READ_LATENCY must be 2");
  end

  // One-hot bank from the two select pins, msb first
  function automatic logic [NUM_BANKS-1:0] bank_onehot(input logic [BANK_W-1:0] b);
    bank_onehot = NUM_BANKS'(1) << b;
  endfunction

  logic [BANK_W-1:0] bankSel;
  scd_cmd_e cmd;
  logic cmdValid;
  logic [ROW_W-1:0] openRow_r [NUM_BANKS];
  logic [NUM_BANKS-1:0] bankActive_r;
  logic [BANK_W-1:0] burstBank_r;
  logic [COL_W-1:0] burstCol_r;
  logic [2:0] burstLeft_r;
  logic burstWrite_r;
  logic autoPre_r;
  logic [READ_LATENCY:0] readPipe_r;
  logic [DATA_W-1:0] dataPipe_r [READ_LATENCY];
  logic colStart;
  logic burstGo;
  logic [NUM_BANKS-1:0] bankOpen;
  logic [NUM_BANKS-1:0] bankClose;
  logic [1:0] maskPipe_r [READ_LATENCY];
  logic [1:0] laneMask;
  logic [MEM_AW-1:0] fullAddr;
  logic [DATA_W-1:0] readData;
  logic memWrite;

  assign bankSel = {bank_select_msb, bank_select_lsb};
  assign cmd = scd_cmd_e'({rowStrobeN, colStrobeN, writeStrobeN});
  assign cmdValid = !chipSelectN;

  // Column command to an open bank restarts the burst; stop cuts it
  assign colStart = cmdValid && (cmd == CMD_READ || cmd == CMD_WRITE)
                    && bankActive_r[bankSel];
  assign burstGo = (burstLeft_r != 3'h0) && !colStart
                   && !(cmdValid && cmd == CMD_STOP);

  // Column address of the current beat, column is low nine address bits
  always_comb begin
    if (burstGo) begin
      fullAddr = {burstBank_r, openRow_r[burstBank_r], burstCol_r};
    end else begin
      fullAddr = {bankSel, openRow_r[bankSel], addrPins[COL_W-1:0]};
    end
  end

  // Write beats: first beat with the command, later beats from the burst
  assign laneMask = {upper_byte_mask, lower_byte_mask};
  assign memWrite = (colStart && cmd == CMD_WRITE)
                    || (burstGo && burstWrite_r);

  scd_mem #(
    .AW(STORE_AW),
    .DW(DATA_W)
  ) u_mem (
    .mclk(mclk),
    .writeEn(memWrite),
    .byteEn(~laneMask),
    .writeAddr(fullAddr[STORE_AW-1:0]),
    .writeData(dataBusIn),
    .readAddr(fullAddr[STORE_AW-1:0]),
    .readData(readData)
  );

  // Opens and closes for this edge; a close wins over an open of that bank
  always_comb begin
    bankOpen = '0;
    bankClose = '0;
    if (cmdValid && cmd == CMD_ROW_OPEN) begin
      bankOpen = bank_onehot(bankSel);
    end
    if (cmdValid && cmd == CMD_PRECHARGE) begin
      if (addrPins[AP_BIT]) begin
        bankClose = {NUM_BANKS{1'b1}};
      end else begin
        bankClose = bank_onehot(bankSel);
      end
    end
    // Auto-precharge on the last beat must not swallow a command elsewhere
    if (burstLeft_r == 3'h1 && autoPre_r) begin
      bankClose = bankClose | bank_onehot(burstBank_r);
    end
  end

  // Bank state: activate opens, precharge closes one or all
  always_ff @(posedge mclk) begin
    if (rst) begin
      bankActive_r <= BANKS_IDLE;
    end else begin
      bankActive_r <= (bankActive_r | bankOpen) & ~bankClose;
    end
  end

  // Row address latched per bank at activate
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : gRow
      always_ff @(posedge mclk) begin
        if (rst) begin
          openRow_r[g] <= '0;
        end else if (cmdValid && cmd == CMD_ROW_OPEN && bankSel == BANK_W'(g)) begin
          openRow_r[g] <= addrPins;
        end
      end
    end
  endgenerate

  // Burst sequencer; a new column command to an open bank or stop cuts the old burst
  always_ff @(posedge mclk) begin
    if (rst) begin
      burstLeft_r <= 3'h0;
      burstBank_r <= BANK_A;
      burstCol_r <= '0;
      burstWrite_r <= 1'b0;
      autoPre_r <= 1'b0;
    end else if (cmdValid && (cmd == CMD_READ || cmd == CMD_WRITE)
                 && bankActive_r[bankSel]) begin
      burstLeft_r <= 3'(BURST_LEN - 1);
      burstBank_r <= bankSel;
      burstCol_r <= addrPins[COL_W-1:0] + 9'h001;
      burstWrite_r <= (cmd == CMD_WRITE);
      autoPre_r <= addrPins[AP_BIT];
    end else if ((cmdValid && cmd == CMD_STOP) || burstLeft_r == 3'h0) begin
      burstLeft_r <= 3'h0;
      autoPre_r <= 1'b0;
    end else begin
      burstLeft_r <= burstLeft_r - 3'h1;
      burstCol_r <= burstCol_r + 9'h001;
    end
  end

  // Read beat marker and its lane mask delayed to the data slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      readPipe_r <= '0;
      maskPipe_r[0] <= 2'h3;
      maskPipe_r[1] <= 2'h3;
    end else begin
      readPipe_r[0] <= (colStart && cmd == CMD_READ)
                       || (burstGo && !burstWrite_r);
      readPipe_r[READ_LATENCY:1] <= readPipe_r[READ_LATENCY-1:0];
      maskPipe_r[0] <= laneMask;
      maskPipe_r[1] <= maskPipe_r[0];
    end
  end

  // Read word held two more edges so it lines up with its lane mask
  always_ff @(posedge mclk) begin
    dataPipe_r[0] <= readData;
    dataPipe_r[1] <= dataPipe_r[0];
  end

  // Output drivers; a masked lane stays undriven on reads
  always_ff @(posedge mclk) begin
    if (rst) begin
      dataBusOut <= '0;
      dataBusOe <= '0;
    end else begin
      dataBusOut <= dataPipe_r[READ_LATENCY-1];
      dataBusOe <= {{8{readPipe_r[READ_LATENCY] && !maskPipe_r[READ_LATENCY-1][1]}},
                    {8{readPipe_r[READ_LATENCY] && !maskPipe_r[READ_LATENCY-1][0]}}};
    end
  end

  // Mode op-code latch, taken from the address pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      modeCode <= MODE_RST;
    end else if (cmdValid && cmd == CMD_MODE) begin
      modeCode <= addrPins;
    end
  end

  // Flags a column command to an idle bank, which is dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmdError <= 1'b0;
    end else begin
      cmdError <= cmdValid && (cmd == CMD_READ || cmd == CMD_WRITE)
                  && !bankActive_r[bankSel];
    end
  end

  assign bankActive = bankActive_r;
endmodule
`default_nettype wire

// ==== verification/scd_decode_sva.sv ====
/* Assertions on the scd_decode pins.
   Bound to every scd_decode; one clock mclk, reset rst. */
`timescale 1ns/10ps
`default_nettype none
module scd_decode_sva
  import scd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeStrobeN,
  input wire logic bank_select_msb,
  input wire logic bank_select_lsb,
  input wire logic [ROW_W-1:0] addrPins,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [DATA_W-1:0] dataBusOe,
  input wire logic [NUM_BANKS-1:0] bankActive,
  input wire logic [ROW_W-1:0] modeCode,
  input wire logic cmdError
);
  logic [2:0] cmd;
  logic [1:0] bank;
  logic colCmd, pre, lanes;
  // Deselect folds into no-op so one compare covers chip select
  assign cmd = chipSelectN ? CMD_NOP : {rowStrobeN, colStrobeN, writeStrobeN};
  assign bank = {bank_select_msb, bank_select_lsb};
  assign colCmd = cmd == CMD_READ || cmd == CMD_WRITE;
  assign pre = cmd == CMD_PRECHARGE;
  assign lanes = !lower_byte_mask && !upper_byte_mask;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_mode_load: assert property (cmd == CMD_MODE |=> modeCode == $past(addrPins))
    else $error("mode code not loaded");
  a_row_open: assert property (cmd == CMD_ROW_OPEN |=> bankActive[$past(bank)])
    else $error("bank not opened");
  a_bank_close: assert property (pre && !addrPins[AP_BIT] |=> !bankActive[$past(bank)])
    else $error("bank not closed");
  a_all_close: assert property (pre && addrPins[AP_BIT] |=> bankActive == BANKS_IDLE)
    else $error("banks not all closed");
  a_idle_error: assert property (colCmd && !bankActive[bank] |=> cmdError)
    else $error("no error flag");
  a_error_cause: assert property (cmdError |-> $past(colCmd && !bankActive[bank]))
    else $error("spurious error flag");
  // Read needs open lanes and a quiet bus for the rest of its latency
  a_burst_read: assert property (cmd == CMD_READ && bankActive[bank] && lanes ##1
    (chipSelectN && lanes) [*4] |-> (dataBusOe == 16'hFFFF) [*4] ##1 dataBusOe == 16'h0000)
    else $error("read burst shape");
  a_lane_whole: assert property (dataBusOe == {{8{dataBusOe[8]}}, {8{dataBusOe[0]}}})
    else $error("lane enable split");
  c_read: cover property (cmd == CMD_READ && bankActive[bank]);
  c_error: cover property (cmdError);
  c_mode: cover property (cmd == CMD_MODE);
endmodule
bind scd_decode scd_decode_sva scd_decode_sva_inst (.mclk, .rst, .chipSelectN, .rowStrobeN,
  .colStrobeN, .writeStrobeN, .bank_select_msb, .bank_select_lsb, .addrPins,
  .lower_byte_mask, .upper_byte_mask, .dataBusOe, .bankActive, .modeCode, .cmdError);
`default_nettype wire

// ==== verification/scd_ctrl_model.sv ====
/* Memory controller model driving the command pins.
   Changes pins after falling edges of mclk only. */
`timescale 1ns/10ps
`default_nettype none
module scd_ctrl_model
  import scd_pkg::*;
(
  input wire logic mclk,
  output logic [19:0] pins,
  output logic [15:0] wdata
);
  // Deselected at start so nothing decodes during reset
  initial begin
    pins = {1'b1, CMD_NOP, 16'h0000};
    wdata = 16'h0000;
  end
  // Command over one rising edge, write beats on the next ones
  task automatic issue(input logic [2:0] c, input logic [1:0] b, m, input logic [11:0] a,
    input logic [15:0] d, input int n);
    @(negedge mclk);
    pins = {1'b0, c, b, m, a};
    wdata = d;
    for (int k = 1; k <= n; k++) begin
      @(negedge mclk);
      pins[19] = 1'b1;
      wdata = (k < n) ? d + 16'(k) : ~wdata;
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/* Self-checking bench for scd_decode with the controller model.
   Needs scd_pkg, scd_decode, the checker and the model first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin err_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module testbench;
  import scd_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] pins;
  logic [15:0] wdata, dataBusOut, dataBusOe, busWire, d;
  logic [NUM_BANKS-1:0] bankActive;
  logic [ROW_W-1:0] modeCode;
  logic cmdError;
  logic [1:0] b, m;
  logic [11:0] a;
  logic [31:0] lfsr = 32'h0BAE;
  int err_count = 0;
  int checked = 0;
  // 200 MHz
  always #2.5 mclk = ~mclk;
  // Wire level: device lanes where enabled, controller elsewhere
  assign busWire = (dataBusOe & dataBusOut) | (~dataBusOe & wdata);
  scd_ctrl_model scd_ctrl_model_inst (.mclk, .pins, .wdata);
  scd_decode scd_decode_inst (.mclk, .rst, .chipSelectN(pins[19]), .rowStrobeN(pins[18]),
    .colStrobeN(pins[17]), .writeStrobeN(pins[16]), .bank_select_msb(pins[15]),
    .bank_select_lsb(pins[14]), .upper_byte_mask(pins[13]), .lower_byte_mask(pins[12]),
    .addrPins(pins[11:0]), .dataBusIn(busWire), .dataBusOut, .dataBusOe, .bankActive,
    .modeCode, .cmdError);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Masked write lanes keep the older data
  function automatic logic [15:0] expw(input logic [15:0] d1, d2, input logic [1:0] wm,
    input int k);
    logic [15:0] x, y;
    x = d1 + 16'(k);
    y = d2 + 16'(k);
    return {wm[1] ? x[15:8] : y[15:8], wm[0] ? x[7:0] : y[7:0]};
  endfunction
  task automatic final_report();
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic go(input logic [2:0] c, input logic [1:0] bk, mk, input logic [11:0] ad,
    input int n);
    scd_ctrl_model_inst.issue(c, bk, mk, ad, d, n);
  endtask
  // Read at b/a; beats land three edges later, masked lanes float
  task automatic rdchk(input logic [1:0] rm, input logic [15:0] d1, d2, input logic [1:0] wm);
    logic [15:0] oe;
    oe = {{8{~rm[1]}}, {8{~rm[0]}}};
    go(CMD_READ, b, rm, a, 1);
    repeat (2) @(negedge mclk);
    for (int k = 0; k < BURST_LEN; k++) begin
      @(negedge mclk);
      `CHK("dataBusOe", oe, dataBusOe)
      `CHK("dataBusOut", expw(d1, d2, wm, k) & oe, dataBusOut & oe)
    end
  endtask
  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    final_report();
  end
  initial begin
    {d, b, m, a} = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    `CHK("bankActive", BANKS_IDLE, bankActive)
    go(CMD_READ, BANK_D, 2'h0, 12'h000, 1);
    `CHK("cmdError", 1'b1, cmdError)
    // Random bank, row, column, data and mask
    for (int i = 0; i < 6; i++) begin
      repeat (32) lfsr = nxt(lfsr);
      {m, b, a} = {lfsr[26:23], 3'h0, lfsr[20:12]};
      d = lfsr[15:0];
      go(CMD_ROW_OPEN, b, 2'h0, lfsr[31:20], 1);
      `CHK("bankActive", 1'b1, bankActive[b])
      go(CMD_WRITE, b, 2'h0, a, BURST_LEN);
      d = ~d;
      go(CMD_WRITE, b, m, a, BURST_LEN);
      rdchk(2'h0, ~d, d, m);
      rdchk(m, ~d, d, m);
      go(CMD_PRECHARGE, b, 2'h0, a, 1);
      `CHK("bankActive", 1'b0, bankActive[b])
    end
    // Auto-precharge closes the bank after the last beat
    b = BANK_C;
    go(CMD_ROW_OPEN, b, 2'h0, 12'h0AB, 1);
    go(CMD_WRITE, b, 2'h0, a, BURST_LEN);
    a[AP_BIT] = 1'b1;
    rdchk(2'h0, d, d, 2'h0);
    @(negedge mclk);
    `CHK("bankActive", 1'b0, bankActive[b])
    for (int k = 0; k < NUM_BANKS; k++) go(CMD_ROW_OPEN, 2'(k), 2'h0, a, 1);
    `CHK("bankActive", 4'hF, bankActive)
    go(CMD_PRECHARGE, BANK_B, 2'h0, 12'h400, 1);
    `CHK("bankActive", BANKS_IDLE, bankActive)
    go(CMD_MODE, 2'h0, 2'h0, lfsr[11:0], 1);
    `CHK("modeCode", lfsr[11:0], modeCode)
    go(CMD_REFRESH, 2'h0, 2'h0, 12'h000, 1);
    go(CMD_STOP, 2'h0, 2'h0, 12'h000, 1);
    @(negedge mclk);
    scd_ctrl_model_inst.pins[18:0] = {CMD_MODE, 4'h0, ~lfsr[11:0]};
    @(negedge mclk);
    `CHK("modeCode", lfsr[11:0], modeCode)
    final_report();
  end
endmodule
`default_nettype wire
